// ==== bench/tb_temperature_conversion_result.sv ====
`timescale 1ns/1ps
module tb_temperature_conversion_result;
	localparam int P_CONV = 50;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [9:0] i_adc_code = 10'h000;
	logic i_ce, i_sck, i_sdi, o_sdo, o_sdo_oe, o_converting, o_shutdown;
	logic [23:0] rd;
	int errors = 0;
	int samples_checked = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	tcr_sensor #(.P_CONV_CYCLES(P_CONV)) u_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_adc_code(i_adc_code),
		.i_ce(i_ce), .i_sck(i_sck), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_converting(o_converting),
		.o_shutdown(o_shutdown));
	tcr_host_model u_host (.i_clk(i_clk_sys), .o_ce(i_ce), .o_sck(i_sck), .o_sdi(i_sdi), .i_sdo(o_sdo),
		.i_sdo_oe(o_sdo_oe));
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 500 && o_converting !== 1'b0; n++) begin
			@(posedge i_clk_sys);
		end
		if (n == 500) begin
			errors++;
			final_report();
		end
	endtask
	task automatic test_reset();
		check({o_shutdown, o_converting}, 24'h2);
		u_host.xfer(1'b0, 8'h02, 8'h00, 2, rd);
		check(rd, 24'h0);
		$display("test_reset done");
	endtask
	task automatic test_oneshot();
		// ends of the code range plus reference points
		logic [9:0] codes [6] = '{10'h1f4, 10'h064, 10'h3ff, 10'h324, 10'h200, 10'h1ff};
		for (int i = 0; i < 6; i++) begin
			@(posedge i_clk_sys) i_adc_code <= codes[i];
			u_host.xfer(1'b0, 8'h80, 8'h11, 1, rd);
			wait_idle();
			check({o_shutdown, o_converting}, 24'h2);
			u_host.xfer(1'b0, 8'h02, 8'h00, 3, rd);
			check(rd, {codes[i], 6'h00, 8'h01});
		end
		$display("test_oneshot done");
	endtask
	task automatic test_continuous();
		@(posedge i_clk_sys) i_adc_code <= 10'h0a6;
		u_host.xfer(1'b1, 8'h80, 8'h00, 1, rd);
		repeat (2 * P_CONV) @(posedge i_clk_sys);
		check({o_shutdown, o_converting}, 24'h1);
		u_host.xfer(1'b1, 8'h02, 8'h00, 2, rd);
		check(rd, 24'h2980);
		@(posedge i_clk_sys) i_adc_code <= 10'h3f6;
		repeat (2 * P_CONV) @(posedge i_clk_sys);
		// code moves mid-frame, the word read must still be the one held at select
		fork
			u_host.xfer(1'b1, 8'h02, 8'h00, 2, rd);
			begin
				repeat (60) @(posedge i_clk_sys);
				i_adc_code <= 10'h1a5;
			end
		join
		check(rd, 24'hfd80);
		u_host.xfer(1'b0, 8'h02, 8'h00, 2, rd);
		check(rd, 24'h6940);
		u_host.xfer(1'b0, 8'h80, 8'h01, 1, rd);
		wait_idle();
		repeat (3 * P_CONV) @(posedge i_clk_sys);
		check({o_shutdown, o_converting}, 24'h2);
		$display("test_continuous done");
	endtask
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		test_reset();
		test_oneshot();
		test_continuous();
		final_report();
	end
endmodule

// ==== bench/tcr_host_model.sv ====
`timescale 1ns/1ps
module tcr_host_model (
	input wire logic i_clk,
	output logic o_ce,
	output logic o_sck,
	output logic o_sdi,
	input wire logic i_sdo,
	input wire logic i_sdo_oe
);
	initial begin
		o_ce = 1'b0;
		o_sck = 1'b0;
		o_sdi = 1'b0;
	end
	// cpol is the sck idle level at select: data out on the leaving edge, sampled on the return edge
	task automatic xfer(input logic cpol, input logic [7:0] addr, input logic [7:0] wdata, input int nbytes,
		output logic [23:0] rdata);
		rdata = 24'h0;
		@(posedge i_clk);
		o_sck <= cpol;
		#100;
		o_ce <= 1'b1;
		#400;
		for (int b = 0; b <= nbytes; b++) begin
			for (int k = 7; k >= 0; k--) begin
				o_sck <= ~cpol;
				o_sdi <= (b == 0) ? addr[k] : wdata[k];
				#62.5;
				o_sck <= cpol;
				if (b > 0) begin
					rdata = {rdata[22:0], i_sdo_oe ? i_sdo : 1'bx};
				end
				#62.5;
			end
		end
		#88;
		o_ce <= 1'b0;
		// released line flips so a stale bit never reads as data
		o_sdi <= ~o_sdi;
		#400;
	endtask
endmodule

// ==== bench/tcr_sensor_chk.sv ====
`timescale 1ns/1ps
module tcr_sensor_chk #(
	parameter int unsigned P_CONV_CYCLES = 50
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [9:0] i_adc_code,
	input wire logic i_ce,
	input wire logic i_sck,
	input wire logic i_sdi,
	input wire logic o_sdo,
	input wire logic o_sdo_oe,
	input wire logic o_converting,
	input wire logic o_shutdown
);
	int unsigned run_len;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	sequence s_conv_end;
		$fell(o_converting);
	endsequence
	// back-to-back runs give multiples of one conversion
	always_ff @(posedge i_clk_sys) begin
		run_len <= (i_sys_rst || !o_converting) ? 0 : run_len + 1;
	end
	a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=> o_shutdown && !o_converting && !o_sdo_oe)
		else $error("reset state wrong");
	a_conv_length: assert property (s_conv_end |-> run_len % P_CONV_CYCLES == 0)
		else $error("conversion length off");
	a_oneshot_return: assert property (s_conv_end ##0 o_shutdown |=> !o_converting)
		else $error("no return to shutdown");
	a_continuous_runs: assert property (s_conv_end ##0 !o_shutdown |-> ##[1:2] o_converting)
		else $error("continuous mode stalled");
	a_continuous_hold: assert property (!o_shutdown && o_converting |=> o_converting)
		else $error("continuous run broke off");
	a_clear_starts: assert property ($fell(o_shutdown) |-> ##[0:2] o_converting)
		else $error("clear did not start");
	a_shutdown_idle: assert property (o_shutdown && !o_converting && !i_ce && !$past(i_ce, 4) |=> !o_converting)
		else $error("conversion in shutdown");
	a_oe_release: assert property ($fell(i_ce) |-> ##[1:6] !o_sdo_oe)
		else $error("sdo not released");
	a_sdo_hold: assert property (o_sdo_oe && !i_ce |=> $stable(o_sdo) || !o_sdo_oe)
		else $error("sdo moved after frame");
endmodule
bind tcr_sensor tcr_sensor_chk #(.P_CONV_CYCLES(P_CONV_CYCLES)) u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
	.i_adc_code(i_adc_code), .i_ce(i_ce), .i_sck(i_sck), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
	.o_converting(o_converting), .o_shutdown(o_shutdown));

// ==== logic/tcr_sensor.sv ====
`timescale 1ns/1ps
`include "tcr_params.svh"
module tcr_sensor #(
	parameter int unsigned P_CONV_CYCLES = `TCR_CONV_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [9:0] i_adc_code,
	input wire logic i_ce,
	input wire logic i_sck,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_oe,
	output logic o_converting,
	output logic o_shutdown
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic ce_s;
	logic sck_s;
	logic sdi_s;

	tcr_sync u_sync_ce (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_async(i_ce), .o_sync(ce_s));
	tcr_sync u_sync_sck (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_async(i_sck), .o_sync(sck_s));
	tcr_sync u_sync_sdi (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_async(i_sdi), .o_sync(sdi_s));

	logic ce_d_reg;
	logic sck_d_reg;
	logic cp_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ce_d_reg <= 1'b0;
			sck_d_reg <= 1'b0;
		end else begin
			ce_d_reg <= ce_s;
			sck_d_reg <= sck_s;
		end
	end

	wire ce_rise = ce_s & ~ce_d_reg;
	wire sck_rise = ce_s & ce_d_reg & sck_s & ~sck_d_reg;
	wire sck_fall = ce_s & ce_d_reg & ~sck_s & sck_d_reg;
	// idle level seen at select picks the polarity
	wire sample_edge = cp_reg ? sck_rise : sck_fall;
	wire shift_edge = cp_reg ? sck_fall : sck_rise;
	// edges count only once ce has stood a cycle, so a select glitch shifts nothing

	// ****************************************
	// control register
	// ****************************************
	// other control bits are not stored and read back as zero
	logic shutdown_reg;
	logic oneshot_reg;
	logic conv_done;
	logic ctrl_wr;
	logic [7:0] wr_byte;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			shutdown_reg <= `TCR_CTRL_SHUTDOWN_RESET;
		end else if (ctrl_wr) begin
			shutdown_reg <= wr_byte[`TCR_CTRL_SHUTDOWN_BIT];
		end
	end

	// a fresh request written in the completing cycle wins over the clear
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			oneshot_reg <= `TCR_CTRL_ONESHOT_RESET;
		end else if (ctrl_wr) begin
			oneshot_reg <= wr_byte[`TCR_CTRL_ONESHOT_BIT];
		end else if (conv_done) begin
			oneshot_reg <= 1'b0;
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	// a started conversion always runs to its end, so shutdown never leaves half a result
	tcr_pkg::tcr_conv_state_type state_reg;
	logic [31:0] conv_cnt_reg;
	logic [9:0] result_reg;

	assign conv_done = (state_reg == tcr_pkg::TCR_CONVERT) && (conv_cnt_reg == P_CONV_CYCLES - 1);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_reg <= tcr_pkg::TCR_IDLE;
			conv_cnt_reg <= 32'h0;
		end else begin
			case (state_reg)
				tcr_pkg::TCR_IDLE: begin
					conv_cnt_reg <= 32'h0;
					if (!shutdown_reg || oneshot_reg) begin
						state_reg <= tcr_pkg::TCR_CONVERT;
					end
				end
				tcr_pkg::TCR_CONVERT: begin
					if (conv_done) begin
						conv_cnt_reg <= 32'h0;
						// back-to-back conversions give the 150 ms period
						if (shutdown_reg) begin
							state_reg <= tcr_pkg::TCR_IDLE;
						end
					end else begin
						conv_cnt_reg <= conv_cnt_reg + 32'h1;
					end
				end
				default: begin
					state_reg <= tcr_pkg::TCR_IDLE;
				end
			endcase
		end
	end

	// result buffer only moves at the end of a conversion
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			result_reg <= 10'h000;
		end else if (conv_done) begin
			result_reg <= i_adc_code;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_converting <= 1'b0;
			o_shutdown <= `TCR_CTRL_SHUTDOWN_RESET;
		end else begin
			o_converting <= (state_reg == tcr_pkg::TCR_CONVERT);
			o_shutdown <= shutdown_reg;
		end
	end

	// ****************************************
	// serial port
	// ****************************************
	// snapshot at select keeps a multi-byte read from one conversion
	logic [9:0] snap_reg;
	tcr_pkg::tcr_phase_type phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] addr_reg;
	logic [7:0] tx_reg;
	logic [7:0] rd_byte;
	logic [6:0] rd_addr;
	logic byte_done;

	wire [7:0] rx_full = {rx_reg[6:0], sdi_s};
	assign byte_done = sample_edge && (bit_cnt_reg == `TCR_BYTE_BITS - 4'h1);
	assign wr_byte = rx_full;
	assign ctrl_wr = byte_done && (phase_reg == tcr_pkg::TCR_PHASE_DATA) && addr_reg[`TCR_ADDR_WRITE_BIT]
		&& (addr_reg[6:0] == `TCR_ADDR_CONTROL);
	// next read address: the one just received, or one below the last sent
	assign rd_addr = (phase_reg == tcr_pkg::TCR_PHASE_ADDR) ? rx_full[6:0]
		: ((addr_reg[6:0] == 7'h00) ? 7'h00 : addr_reg[6:0] - 7'h01);

	always_comb begin
		case (rd_addr)
			`TCR_ADDR_CONTROL: rd_byte = 8'h00 | ({7'h00, oneshot_reg} << `TCR_CTRL_ONESHOT_BIT)
				| ({7'h00, shutdown_reg} << `TCR_CTRL_SHUTDOWN_BIT);
			`TCR_ADDR_TEMP_LOW: rd_byte = {snap_reg[1:0], `TCR_LOW_FILL};
			`TCR_ADDR_TEMP_HIGH: rd_byte = snap_reg[9:2];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			snap_reg <= 10'h000;
			cp_reg <= 1'b0;
		end else if (ce_rise) begin
			snap_reg <= result_reg;
			cp_reg <= sck_s;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || !ce_s) begin
			phase_reg <= tcr_pkg::TCR_PHASE_ADDR;
			bit_cnt_reg <= 4'h0;
			rx_reg <= 8'h00;
			addr_reg <= 8'h00;
		end else if (sample_edge) begin
			rx_reg <= rx_full;
			bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
			if (byte_done) begin
				phase_reg <= tcr_pkg::TCR_PHASE_DATA;
				if (phase_reg == tcr_pkg::TCR_PHASE_ADDR) begin
					addr_reg <= rx_full;
				end else if (!addr_reg[`TCR_ADDR_WRITE_BIT]) begin
					addr_reg <= {addr_reg[7], rd_addr};
				end
			end
		end
	end

	// sdo stays high-z until read data shifts, holds last bit until deselect
	// write frames never arm the shifter, so sdo stays released for them
	logic tx_armed_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || !ce_s) begin
			tx_reg <= 8'h00;
			tx_armed_reg <= 1'b0;
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else if (byte_done && !addr_reg[`TCR_ADDR_WRITE_BIT]
			&& !(phase_reg == tcr_pkg::TCR_PHASE_ADDR && rx_full[`TCR_ADDR_WRITE_BIT])) begin
			tx_reg <= rd_byte;
			tx_armed_reg <= 1'b1;
		end else if (shift_edge && tx_armed_reg) begin
			o_sdo <= tx_reg[7];
			o_sdo_oe <= 1'b1;
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end
endmodule

// ==== logic/tcr_sync.sv ====
`timescale 1ns/1ps
// ****************************************
// two-stage level synchroniser
// ****************************************
module tcr_sync (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			meta_reg <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule

// ==== pkg/tcr_params.svh ====
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH
// Functional notes
// - results are 10-bit two's complement codes, one step is 0.25 degC
// - code range spans -128 to +127.75 degC, all codes representable
// - continuous mode starts a new conversion about every 150 ms, stores each result
// - internal timing sequences conversions endlessly until a control write sets shutdown
// - in shutdown no continuous conversions run until shutdown bit is cleared
// - one-shot does exactly one conversion, updates results, then returns to shutdown
// - results double-buffered; serial reads never disturb conversions, always consistent
// - high byte at 02h holds sign in bit 7, integer weights in bits 6..0
// - high-then-low word gives 7d00, 1900, ffc0, c900 for reference temperatures
// - shutdown bit one means shutdown, zero means continuous conversion
// - after power-up the block sits in shutdown until the control register is written

// ****************************************
// register map
// ****************************************
`define TCR_ADDR_CONTROL 7'h00
`define TCR_ADDR_TEMP_LOW 7'h01
`define TCR_ADDR_TEMP_HIGH 7'h02
`define TCR_ADDR_WRITE_BIT 7
`define TCR_CTRL_SHUTDOWN_BIT 0
`define TCR_CTRL_ONESHOT_BIT 4
`define TCR_CTRL_SHUTDOWN_RESET 1'b1
`define TCR_CTRL_ONESHOT_RESET 1'b0
`define TCR_LOW_FILL 6'h00

// ****************************************
// timing
// ****************************************
`define TCR_CLK_MHZ 100
`define TCR_CONV_TIME_MS 150
`define TCR_CONV_CYCLES (`TCR_CONV_TIME_MS * 1000 * `TCR_CLK_MHZ)
`define TCR_BYTE_BITS 4'h8
`endif

// ==== pkg/tcr_pkg.sv ====
package tcr_pkg;
	typedef enum logic [0:0] {
		TCR_IDLE,
		TCR_CONVERT
	} tcr_conv_state_type;

	typedef enum logic [0:0] {
		TCR_PHASE_ADDR,
		TCR_PHASE_DATA
	} tcr_phase_type;
endpackage
